/* File: rtl/tcc_pkg.sv */
package tcc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_WR0 = 3'h0;
  localparam logic [2:0] IDX_WR1 = 3'h1;
  localparam logic [2:0] IDX_WR2 = 3'h2;
  localparam logic [2:0] IDX_WR3 = 3'h3;
  localparam logic [2:0] IDX_WR5 = 3'h5;
  localparam logic [2:0] IDX_WR6 = 3'h6;
  localparam logic [2:0] IDX_RR0 = 3'h0;
  localparam logic [2:0] IDX_RR1 = 3'h1;
  localparam logic [2:0] IDX_RR2 = 3'h2;
  localparam logic [2:0] IDX_RR3 = 3'h3;
  // Write register 0 fields
  localparam int B_WRITE_OFF  = 1;
  localparam int B_CRC_APPEND = 3;
  localparam int B_WRITE_ON   = 4;
  localparam int B_STAT_CLR   = 5;
  localparam int B_SOFT_RST   = 7;
  // Write register 1 fields
  localparam int B_GAPREQ_OFF = 1;
  localparam int B_GAPREQ_ON  = 2;
  localparam int B_RDREQ_OFF  = 3;
  localparam int B_RDREQ_ON   = 4;
  localparam int B_RDREQ_CLR  = 6;
  localparam int B_WRREQ_CLR  = 7;
  // Write register 3 fields
  localparam int B_REWIND     = 3;
  localparam int B_REW_HOLD   = 4;
  localparam int B_CMD_LSB    = 5;
  // Write register 5 and 6 fields
  localparam int B_READ_OFF   = 3;
  localparam int B_READ_ON    = 4;
  localparam int B_UNIT       = 0;
  // Reset values and CRC
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] CRC_INIT   = 16'h0000;
  localparam logic [2:0]  LAST_BIT   = 3'h7;
  localparam logic [3:0]  LAST_CRC   = 4'hf;

  function automatic logic [15:0] tcc_crc_step(input logic [15:0] crc, input logic din);
    tcc_crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ din) ? CRC_POLY : 16'h0000);
  endfunction
endpackage

/* File: rtl/tcc_wr_if.sv */
`timescale 1ns/1ps
interface tcc_wr_if;
  logic [7:0] byte_data;
  logic       byte_valid;
  logic       byte_take;
  logic       crc_en;
  logic       mode_en;
  logic       wck_edge;
  logic       clr;
  logic       enc_out;
  logic       underrun;
  modport ctrl (output byte_data, byte_valid, crc_en, mode_en, wck_edge, clr,
                input byte_take, enc_out, underrun);
  modport ser  (input byte_data, byte_valid, crc_en, mode_en, wck_edge, clr,
                output byte_take, enc_out, underrun);
endinterface

/* File: rtl/tcc_writer.sv */
`timescale 1ns/1ps
module tcc_writer (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Link to controller
  tcc_wr_if.ser     wr
);
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_DATA = 3'b010,
    W_CRC  = 3'b100
  } tcc_wstate_t;

  tcc_wstate_t state;
  logic [7:0]  shift;
  logic [15:0] crc;
  logic [3:0]  cnt;
  logic        half;
  logic        cur_bit;
  logic        bit_end;
  logic        last;

  assign cur_bit = (state == W_CRC) ? crc[15] : shift[7];
  assign bit_end = wr.wck_edge && half && state != W_IDLE;
  assign last    = (state == W_CRC) ? (cnt == tcc_pkg::LAST_CRC)
                                    : (cnt[2:0] == tcc_pkg::LAST_BIT);
  assign wr.byte_take = wr.mode_en && wr.byte_valid && wr.wck_edge &&
                        (state == W_IDLE || (bit_end && last && state == W_DATA));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= W_IDLE;
      shift <= tcc_pkg::BYTE_RESET;
      crc   <= tcc_pkg::CRC_INIT;
      cnt   <= 4'h0;
      half  <= 1'b0;
    end else if (wr.clr || !wr.mode_en) begin
      state <= W_IDLE;
      crc   <= tcc_pkg::CRC_INIT;
      cnt   <= 4'h0;
      half  <= 1'b0;
    end else if (wr.byte_take) begin
      state <= W_DATA;
      shift <= wr.byte_data;
      cnt   <= 4'h0;
      half  <= 1'b0;
      if (state == W_DATA) crc <= tcc_pkg::tcc_crc_step(crc, shift[7]);
    end else if (wr.wck_edge && state != W_IDLE) begin
      half <= ~half;
      if (half) begin
        cnt <= cnt + 4'h1;
        if (state == W_DATA) begin
          shift <= {shift[6:0], 1'b0};
          crc   <= tcc_pkg::tcc_crc_step(crc, shift[7]);
        end else begin
          crc <= {crc[14:0], 1'b0};
        end
        if (last) begin
          cnt <= 4'h0;
          if (state == W_DATA && wr.crc_en) begin
            state <= W_CRC;
          end else begin
            state <= W_IDLE;
            crc   <= tcc_pkg::CRC_INIT;
          end
        end
      end
    end
  end

  // Underrun when a data byte ends with no next byte and no CRC to send
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr.underrun <= 1'b0;
    end else begin
      wr.underrun <= bit_end && last && state == W_DATA && !wr.byte_valid && !wr.crc_en;
    end
  end

  // Phase encoding: inverted level in first half-cell, true level in second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr.enc_out <= 1'b0;
    end else if (state == W_IDLE || wr.clr) begin
      wr.enc_out <= 1'b0;
    end else begin
      wr.enc_out <= half ? cur_bit : ~cur_bit;
    end
  end
endmodule

/* File: rtl/tcc_top.sv */
`timescale 1ns/1ps
module tcc_top (
  // AHB-Lite clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Device reset and service request
  input  wire logic        ext_reset,
  output logic             service_request,
  // Timing inputs and transition pulse output
  input  wire logic        write_bit_clock,
  input  wire logic        sample_gate_reopen,
  input  wire logic        dropout_in,
  input  wire logic        gap_in,
  output logic             transition_pulse,
  // Tape data
  input  wire logic        read_pulse_rise,
  input  wire logic        read_pulse_fall,
  output logic             encoded_write_out,
  // Drive control and status
  output logic [2:0]       drive_command_lines,
  output logic             unit_select,
  output logic             rewind_drive_zero,
  output logic             rewind_drive_one,
  input  wire logic [2:0]  drive_status_inputs,
  input  wire logic        tape_marker_zero,
  input  wire logic        tape_marker_one
);
  function automatic logic in_map(input logic [31:0] a);
    in_map = (a[31:5] == 27'h000_0000) && (a[1:0] == 2'b00);
  endfunction

  tcc_wr_if wr ();

  logic       ap_valid;
  logic       ap_write;
  logic [2:0] ap_idx;
  logic       wr_stb;
  logic [7:0] wdat;
  logic       rd_stb;
  logic [2:0] rd_idx;
  logic       clr;
  logic       soft_rst;
  logic       write_mode;
  logic       crc_append;
  logic [7:0] write_buffer;
  logic       wbuf_full;
  logic       wrq;
  logic       rdreq_en;
  logic       gapreq_en;
  logic       read_mode;
  logic       rrq;
  logic       grq;
  logic       rdf;
  logic [7:0] read_buffer;
  logic [7:0] rshift;
  logic [2:0] rcnt;
  logic [15:0] rcrc;
  logic       rec;
  logic       gate_open;
  logic       sg_prev;
  logic       do_prev;
  logic       gap_prev;
  logic       wck_prev;
  logic       gpf;
  logic       doe;
  logic       cre;
  logic       cor;
  logic       mkf;
  logic       rew_hold;
  logic [2:0] cmd;
  logic [1:0] rewind;
  logic [1:0] mk_prev;
  logic [1:0] mk_now;
  logic       tr;
  logic       bit_evt;
  logic       bit_val;
  logic       byte_done;
  logic       gap_evt;
  logic [7:0] rd_mux;

  // Bus strobes
  assign wr_stb    = ap_valid && ap_write;
  assign wdat      = hwdata[7:0];
  assign rd_stb    = hsel && htrans[1] && hready && !hwrite && in_map(haddr);
  assign rd_idx    = haddr[4:2];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign clr       = ext_reset || soft_rst;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_idx   <= 3'h0;
    end else begin
      ap_valid <= hsel && htrans[1] && hready && in_map(haddr);
      ap_write <= hwrite;
      ap_idx   <= haddr[4:2];
    end
  end

  // Read mux
  always_comb begin
    rd_mux = 8'h00;
    unique case (rd_idx)
      tcc_pkg::IDX_RR0: rd_mux = {1'b1, 1'b0, cmd[1], cmd[2], rdf, grq, wrq, rrq};
      tcc_pkg::IDX_RR1: rd_mux = {drive_status_inputs[2], mk_now[unit_select], mkf,
                                  drive_status_inputs[1], drive_status_inputs[0],
                                  rewind[unit_select], cmd[0], unit_select};
      tcc_pkg::IDX_RR2: rd_mux = read_buffer;
      tcc_pkg::IDX_RR3: rd_mux = {encoded_write_out, gpf, rec, cre, doe, cor, 2'b00};
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_stb) begin
      hrdata <= {24'h00_0000, rd_mux};
    end
  end

  // Write register 0, 1 and 5 controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_rst   <= 1'b0;
      write_mode <= 1'b0;
      crc_append <= 1'b0;
      rdreq_en   <= 1'b0;
      gapreq_en  <= 1'b0;
      read_mode  <= 1'b0;
    end else begin
      soft_rst <= wr_stb && ap_idx == tcc_pkg::IDX_WR0 && wdat[tcc_pkg::B_SOFT_RST];
      if (clr) begin
        write_mode <= 1'b0;
        crc_append <= 1'b0;
        rdreq_en   <= 1'b0;
        gapreq_en  <= 1'b0;
        read_mode  <= 1'b0;
      end else if (wr_stb) begin
        if (ap_idx == tcc_pkg::IDX_WR0) begin
          crc_append <= wdat[tcc_pkg::B_CRC_APPEND];
          if (wdat[tcc_pkg::B_WRITE_ON]) write_mode <= 1'b1;
          if (wdat[tcc_pkg::B_WRITE_OFF]) write_mode <= 1'b0;
        end
        if (ap_idx == tcc_pkg::IDX_WR1) begin
          if (wdat[tcc_pkg::B_RDREQ_ON]) rdreq_en <= 1'b1;
          if (wdat[tcc_pkg::B_RDREQ_OFF]) rdreq_en <= 1'b0;
          if (wdat[tcc_pkg::B_GAPREQ_ON]) gapreq_en <= 1'b1;
          if (wdat[tcc_pkg::B_GAPREQ_OFF]) gapreq_en <= 1'b0;
        end
        if (ap_idx == tcc_pkg::IDX_WR5) begin
          if (wdat[tcc_pkg::B_READ_ON]) read_mode <= 1'b1;
          if (wdat[tcc_pkg::B_READ_OFF]) read_mode <= 1'b0;
        end
      end
    end
  end

  // Write buffer and write request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_buffer <= tcc_pkg::BYTE_RESET;
      wbuf_full    <= 1'b0;
      wrq          <= 1'b0;
    end else if (clr) begin
      wbuf_full <= 1'b0;
      wrq       <= 1'b0;
    end else begin
      if (wr_stb && ap_idx == tcc_pkg::IDX_WR2) begin
        write_buffer <= wdat;
        wbuf_full    <= 1'b1;
      end else if (wr.byte_take) begin
        wbuf_full <= 1'b0;
      end
      if (wr.byte_take) begin
        wrq <= 1'b1;
      end else if ((wr_stb && ap_idx == tcc_pkg::IDX_WR2) ||
                   (wr_stb && ap_idx == tcc_pkg::IDX_WR1 && wdat[tcc_pkg::B_WRREQ_CLR])) begin
        wrq <= 1'b0;
      end
    end
  end

  // Serializer link
  assign wr.byte_data  = write_buffer;
  assign wr.byte_valid = wbuf_full;
  assign wr.crc_en     = crc_append;
  assign wr.mode_en    = write_mode;
  assign wr.wck_edge   = write_bit_clock && !wck_prev;
  assign wr.clr        = clr;
  assign encoded_write_out = wr.enc_out;

  tcc_writer u_writer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr      (wr.ser)
  );

  // Read path edges and write clock edge; read path independent of the write path
  assign tr        = read_pulse_rise || read_pulse_fall;
  assign bit_val   = read_pulse_rise;
  assign bit_evt   = read_mode && tr && gate_open;
  assign byte_done = bit_evt && (rec || bit_val) && rcnt == tcc_pkg::LAST_BIT;
  assign gap_evt   = gap_in && !gap_prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transition_pulse <= 1'b0;
      gate_open        <= 1'b1;
      sg_prev          <= 1'b0;
      do_prev          <= 1'b0;
      gap_prev         <= 1'b0;
      wck_prev         <= 1'b0;
    end else begin
      transition_pulse <= tr && !clr;
      sg_prev          <= sample_gate_reopen;
      do_prev          <= dropout_in;
      gap_prev         <= gap_in;
      wck_prev         <= write_bit_clock;
      if (clr) begin
        gate_open <= 1'b1;
      end else if (tr) begin
        gate_open <= 1'b0;
      end else if (sample_gate_reopen && !sg_prev) begin
        gate_open <= 1'b1;
      end
    end
  end

  // Read shifter, CRC check and record state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rshift      <= tcc_pkg::BYTE_RESET;
      read_buffer <= tcc_pkg::BYTE_RESET;
      rcnt        <= 3'h0;
      rcrc        <= tcc_pkg::CRC_INIT;
      rec         <= 1'b0;
    end else if (clr || gap_evt) begin
      rcnt <= 3'h0;
      rcrc <= tcc_pkg::CRC_INIT;
      rec  <= 1'b0;
    end else if (bit_evt && (rec || bit_val)) begin
      rec    <= 1'b1;
      rshift <= {rshift[6:0], bit_val};
      rcnt   <= rcnt + 3'h1;
      rcrc   <= tcc_pkg::tcc_crc_step(rcrc, bit_val);
      if (byte_done) begin
        read_buffer <= {rshift[6:0], bit_val};
      end
    end
  end

  // Request and error flags; a set wins over a register clear, device reset (clr) wins over both
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rrq <= 1'b0;
      rdf <= 1'b0;
      grq <= 1'b0;
      gpf <= 1'b0;
      doe <= 1'b0;
      cre <= 1'b0;
      cor <= 1'b0;
    end else if (clr) begin
      rrq <= 1'b0;
      rdf <= 1'b0;
      grq <= 1'b0;
      gpf <= 1'b0;
      doe <= 1'b0;
      cre <= 1'b0;
      cor <= 1'b0;
    end else begin
      if (byte_done) begin
        rdf <= 1'b1;
        rrq <= rdreq_en || rrq;
      end else if (rd_stb && rd_idx == tcc_pkg::IDX_RR2) begin
        rdf <= 1'b0;
        rrq <= 1'b0;
      end else if (wr_stb && ap_idx == tcc_pkg::IDX_WR1 && wdat[tcc_pkg::B_RDREQ_CLR]) begin
        rrq <= 1'b0;
      end
      if (gap_evt) begin
        gpf <= 1'b1;
        grq <= gapreq_en || grq;
        cre <= cre || (rec && rcrc != tcc_pkg::CRC_INIT);
      end else if (wr_stb && ap_idx == tcc_pkg::IDX_WR0 && wdat[tcc_pkg::B_STAT_CLR]) begin
        gpf <= 1'b0;
        grq <= 1'b0;
        cre <= 1'b0;
      end
      if (dropout_in && !do_prev && rec) begin
        doe <= 1'b1;
      end else if (wr_stb && ap_idx == tcc_pkg::IDX_WR0 && wdat[tcc_pkg::B_STAT_CLR]) begin
        doe <= 1'b0;
      end
      if (wr.underrun) begin
        cor <= 1'b1;
      end else if (wr_stb && ap_idx == tcc_pkg::IDX_WR0 && wdat[tcc_pkg::B_STAT_CLR]) begin
        cor <= 1'b0;
      end
    end
  end

  assign service_request = rrq || wrq || grq;

  // Drive commands, unit select and rewind
  assign mk_now = {tape_marker_one, tape_marker_zero};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd         <= 3'h0;
      unit_select <= 1'b0;
      rew_hold    <= 1'b0;
      mkf         <= 1'b0;
      mk_prev     <= 2'b00;
    end else begin
      mk_prev <= mk_now;
      if (clr) begin
        cmd         <= 3'h0;
        unit_select <= 1'b0;
        rew_hold    <= 1'b0;
        mkf         <= 1'b0;
      end else begin
        if (wr_stb && ap_idx == tcc_pkg::IDX_WR3) begin
          cmd      <= wdat[tcc_pkg::B_CMD_LSB +: 3];
          rew_hold <= wdat[tcc_pkg::B_REW_HOLD];
        end
        if (wr_stb && ap_idx == tcc_pkg::IDX_WR6) begin
          unit_select <= wdat[tcc_pkg::B_UNIT];
        end
        if (mk_now[unit_select] && !mk_prev[unit_select]) begin
          mkf <= 1'b1;
        end else if (wr_stb && ap_idx == tcc_pkg::IDX_WR0 && wdat[tcc_pkg::B_STAT_CLR]) begin
          mkf <= 1'b0;
        end
      end
    end
  end

  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_drive
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rewind[d] <= 1'b0;
        end else if (clr) begin
          rewind[d] <= 1'b0;
        end else if (wr_stb && ap_idx == tcc_pkg::IDX_WR3 && wdat[tcc_pkg::B_REWIND] &&
                     unit_select == d[0]) begin
          rewind[d] <= 1'b1;
        end else if (mk_now[d] && !mk_prev[d] && !rew_hold) begin
          rewind[d] <= 1'b0;
        end
      end
    end
  endgenerate

  assign drive_command_lines = cmd;
  assign rewind_drive_zero   = rewind[0];
  assign rewind_drive_one    = rewind[1];
endmodule

/* File: verification/tcc_tape_model.sv */
`timescale 1ns/1ps
module tcc_tape_model #(
  parameter int HALF = 8
) (
  // Clock and control
  input  wire logic hclk,
  input  wire logic run_wck,
  // Device outputs
  input  wire logic encoded_write_out,
  input  wire logic transition_pulse,
  // Timing and tape data
  output logic      write_bit_clock,
  output logic      sample_gate_reopen,
  output logic      dropout_in,
  output logic      gap_in,
  output logic      read_pulse_rise,
  output logic      read_pulse_fall
);
  localparam int TC = 2 * HALF;
  int   wck_cnt;
  int   sg_cnt;
  int   quiet;
  logic enc_d;
  initial begin
    {write_bit_clock, sample_gate_reopen, dropout_in, gap_in, enc_d} = 5'h00;
    {read_pulse_rise, read_pulse_fall} = 2'h0;
    wck_cnt = 0;
    sg_cnt  = 0;
    quiet   = 1000;
  end
  // Write clock of half a cell, still while stopped
  always @(posedge hclk) begin
    wck_cnt         <= run_wck ? (wck_cnt + 1) % HALF : 0;
    write_bit_clock <= run_wck && (wck_cnt < HALF / 2);
  end
  // Written stream looped back as rise and fall pulses
  always @(posedge hclk) begin
    enc_d           <= encoded_write_out;
    read_pulse_rise <= encoded_write_out && !enc_d;
    read_pulse_fall <= !encoded_write_out && enc_d;
  end
  // Gate timer not retriggered; dropout and gap timers are
  always @(posedge hclk) begin
    if (transition_pulse && sg_cnt == 0) sg_cnt <= 1;
    else if (sg_cnt != 0) sg_cnt <= (sg_cnt == TC * 3 / 4) ? 0 : sg_cnt + 1;
    sample_gate_reopen <= (sg_cnt == TC * 3 / 4);
    quiet      <= transition_pulse ? 0 : (quiet < 1000 ? quiet + 1 : quiet);
    dropout_in <= (quiet == TC * 3 / 2);
    gap_in     <= (quiet == TC * 4);
  end
endmodule

/* File: verification/tcc_checker.sv */
`timescale 1ns/1ps
module tcc_checker (
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Device pins
  input wire logic        ext_reset,
  input wire logic        service_request,
  input wire logic        write_bit_clock,
  input wire logic        transition_pulse,
  input wire logic        read_pulse_rise,
  input wire logic        read_pulse_fall,
  input wire logic        encoded_write_out,
  input wire logic [2:0]  drive_command_lines,
  input wire logic        unit_select,
  input wire logic        rewind_drive_zero,
  input wire logic        rewind_drive_one,
  input wire logic [2:0]  drive_status_inputs
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       wck_d;
  logic [2:0] rise_hist;
  logic       acc;
  assign acc = hsel & htrans[1] & hready & ~ext_reset;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wck_d     <= 1'b0;
      rise_hist <= 3'h0;
    end else begin
      wck_d     <= write_bit_clock;
      rise_hist <= {rise_hist[1:0], write_bit_clock & ~wck_d};
    end
  end
  property p_clear;
    ext_reset |=> drive_command_lines == 3'h0 && !unit_select && !rewind_drive_zero
      && !rewind_drive_one;
  endproperty
  a_clear: assert property (p_clear) else $error("drive outputs kept");
  property p_cmd;
    acc && hwrite && haddr == 32'h0000_000C |-> ##2 drive_command_lines == $past(hwdata[7:5]);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command lines wrong");
  property p_unit;
    acc && hwrite && haddr == 32'h0000_0018 |-> ##2 unit_select == $past(hwdata[0]);
  endproperty
  a_unit: assert property (p_unit) else $error("unit select wrong");
  property p_stat;
    acc && !hwrite && haddr == 32'h0000_0004 |=> hrdata[7] == $past(drive_status_inputs[2])
      && hrdata[4:3] == $past(drive_status_inputs[1:0]) && hrdata[31:8] == 24'h00_0000;
  endproperty
  a_stat: assert property (p_stat) else $error("status bits wrong");
  property p_rr0;
    acc && !hwrite && haddr == 32'h0000_0000 |=> hrdata[7:6] == 2'h2
      && hrdata[5:4] == {$past(drive_command_lines[1]), $past(drive_command_lines[2])};
  endproperty
  a_rr0: assert property (p_rr0) else $error("command readback wrong");
  property p_req;
    acc && !hwrite && haddr == 32'h0000_0000 |=> (|hrdata[2:0]) == $past(service_request);
  endproperty
  a_req: assert property (p_req) else $error("request bits disagree");
  property p_hold;
    !ext_reset && !(acc && !hwrite) |=> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data not held");
  property p_dt;
    1'b1 |-> transition_pulse == $past(read_pulse_rise | read_pulse_fall);
  endproperty
  a_dt: assert property (p_dt) else $error("transition pulse wrong");
  property p_wd;
    $changed(encoded_write_out) && !$past(ext_reset) |-> (|rise_hist);
  endproperty
  a_wd: assert property (p_wd) else $error("write data off clock");
endmodule
bind tcc_top tcc_checker u_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .ext_reset(ext_reset), .service_request(service_request),
  .write_bit_clock(write_bit_clock), .transition_pulse(transition_pulse),
  .read_pulse_rise(read_pulse_rise), .read_pulse_fall(read_pulse_fall),
  .encoded_write_out(encoded_write_out), .drive_command_lines(drive_command_lines),
  .unit_select(unit_select), .rewind_drive_zero(rewind_drive_zero),
  .rewind_drive_one(rewind_drive_one), .drive_status_inputs(drive_status_inputs)
);

/* File: verification/tape_cassette_controller_test.sv */
`timescale 1ns/1ps
module tape_cassette_controller_test;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, drive_command_lines, drive_status_inputs, c, s;
  logic        ext_reset, service_request, write_bit_clock, sample_gate_reopen;
  logic        dropout_in, gap_in, transition_pulse, read_pulse_rise, read_pulse_fall;
  logic        encoded_write_out, unit_select, rewind_drive_zero, rewind_drive_one;
  logic        tape_marker_zero, tape_marker_one, run_wck, rd_phase;
  logic [15:0] crc;
  logic [63:0] note;
  logic [63:0] rd_q[$];
  logic        tape_q[$];
  int          num_errors;
  int          samples_checked;
  tcc_top DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_reset(ext_reset),
    .service_request(service_request), .write_bit_clock(write_bit_clock),
    .sample_gate_reopen(sample_gate_reopen), .dropout_in(dropout_in), .gap_in(gap_in),
    .transition_pulse(transition_pulse), .read_pulse_rise(read_pulse_rise),
    .read_pulse_fall(read_pulse_fall), .encoded_write_out(encoded_write_out),
    .drive_command_lines(drive_command_lines), .unit_select(unit_select),
    .rewind_drive_zero(rewind_drive_zero), .rewind_drive_one(rewind_drive_one),
    .drive_status_inputs(drive_status_inputs), .tape_marker_zero(tape_marker_zero),
    .tape_marker_one(tape_marker_one)
  );
  tcc_tape_model #(.HALF(8)) u_tape (
    .hclk(hclk), .run_wck(run_wck), .encoded_write_out(encoded_write_out),
    .transition_pulse(transition_pulse), .write_bit_clock(write_bit_clock),
    .sample_gate_reopen(sample_gate_reopen), .dropout_in(dropout_in), .gap_in(gap_in),
    .read_pulse_rise(read_pulse_rise), .read_pulse_fall(read_pulse_fall)
  );
  always #5 hclk = ~hclk;
  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [2:0] i, input logic [31:0] d,
                     input logic [31:0] m);
    hsel   <= 1'b1;
    haddr  <= {27'h000_0000, i, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans   <= 2'h0;
    hwdata   <= wr ? d : 32'h0000_0000;
    rd_phase <= !wr;
    if (!wr) rd_q.push_back({d, m});
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask
  task automatic wreg(input logic [2:0] i, input logic [7:0] d);
    bus(1'b1, i, {24'h00_0000, d}, 32'h0000_0000);
  endtask
  task automatic push(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      tape_q.push_back(~v[i]);
      tape_q.push_back(v[i]);
    end
  endtask
  function automatic logic [15:0] crc_of(input logic [7:0] b);
    logic [15:0] r;
    r = tcc_pkg::CRC_INIT;
    for (int i = 7; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? tcc_pkg::CRC_POLY : 16'h0000);
    return r;
  endfunction
  task automatic test_done;
    $display("Checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Read data checked against the oldest note
  always @(posedge hclk) begin
    if (rd_phase === 1'b1 && hreadyout === 1'b1 && rd_q.size() > 0) begin
      note = rd_q.pop_front();
      cmp(note[63:32] & note[31:0], hrdata & note[31:0]);
      cmp(32'h0, {31'h0, hresp});
    end
  end
  // Each half-cell of written data checked mid-cell
  initial forever begin
    @(posedge write_bit_clock);
    repeat (5) @(posedge hclk);
    if (tape_q.size() > 0) cmp({31'h0, tape_q.pop_front()}, {31'h0, encoded_write_out});
  end
  initial begin
    #200_000;
    num_errors++;
    test_done();
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, ext_reset, run_wck, rd_phase} = 7'h00;
    {tape_marker_zero, tape_marker_one} = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    drive_status_inputs = 3'h0;
    num_errors = 0;
    samples_checked = 0;
    void'($urandom(32'hcaff_8fcd));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      c = 3'($urandom);
      s = 3'($urandom);
      drive_status_inputs <= s;
      wreg(tcc_pkg::IDX_WR3, {c, 5'h00});
      wreg(tcc_pkg::IDX_WR6, {7'h00, c[0]});
      @(posedge hclk);
      cmp({29'h0, c}, {29'h0, drive_command_lines});
      cmp({31'h0, c[0]}, {31'h0, unit_select});
      bus(1'b0, tcc_pkg::IDX_RR1, {24'h0, s[2], 2'h0, s[1:0], 1'b0, c[0], c[0]}, 32'h9B);
    end
    wreg(3'h4, 8'hFF);
    bus(1'b0, 3'h7, 32'h0000_0000, 32'hFFFF_FFFF);
    wreg(tcc_pkg::IDX_WR3, 8'hE8);
    ext_reset <= 1'b1;
    repeat (2) @(posedge hclk);
    ext_reset <= 1'b0;
    @(posedge hclk);
    cmp(32'h0, {28'h0, drive_command_lines, rewind_drive_zero});
    bus(1'b0, tcc_pkg::IDX_RR0, 32'h80, 32'hFFFF_FFF0);
    $display("Registers test done");
    wreg(tcc_pkg::IDX_WR3, 8'h08);
    @(posedge hclk);
    cmp(32'h2, {30'h0, rewind_drive_zero, rewind_drive_one});
    wreg(tcc_pkg::IDX_WR5, 8'h10);
    wreg(tcc_pkg::IDX_WR1, 8'h14);
    wreg(tcc_pkg::IDX_WR2, 8'hA5);
    wreg(tcc_pkg::IDX_WR0, 8'h10);
    push(16'h00A5, 8);
    run_wck <= 1'b1;
    @(posedge gap_in);
    repeat (4) @(posedge hclk);
    cmp(32'h1, {31'h0, service_request});
    bus(1'b0, tcc_pkg::IDX_RR3, 32'h50, 32'hD0);
    bus(1'b0, tcc_pkg::IDX_RR2, 32'hA5, 32'hFFFF_FFFF);
    run_wck <= 1'b0;
    wreg(tcc_pkg::IDX_WR1, 8'h80);
    wreg(tcc_pkg::IDX_WR0, 8'h20);
    @(posedge hclk);
    cmp(32'h0, {31'h0, service_request});
    $display("Plain record test done");
    wreg(tcc_pkg::IDX_WR2, 8'hC3);
    wreg(tcc_pkg::IDX_WR0, 8'h18);
    crc = crc_of(8'hC3);
    push(16'h00C3, 8);
    push(crc, 16);
    run_wck <= 1'b1;
    @(posedge gap_in);
    repeat (4) @(posedge hclk);
    bus(1'b0, tcc_pkg::IDX_RR3, 32'h40, 32'hD0);
    bus(1'b0, tcc_pkg::IDX_RR2, {24'h0, crc[7:0]}, 32'hFFFF_FFFF);
    $display("Checked record test done");
    tape_marker_zero <= 1'b1;
    repeat (3) @(posedge hclk);
    cmp(32'h0, {31'h0, rewind_drive_zero});
    wreg(tcc_pkg::IDX_WR6, 8'h01);
    wreg(tcc_pkg::IDX_WR3, 8'h08);
    @(posedge hclk);
    cmp(32'h1, {30'h0, rewind_drive_zero, rewind_drive_one});
    tape_marker_one <= 1'b1;
    repeat (3) @(posedge hclk);
    cmp(32'h0, {31'h0, rewind_drive_one});
    $display("Rewind test done");
    test_done();
  end
endmodule
